// [hw/vc3_nonintrusive_monitor.sv]
/*
 VC-3 path non-intrusive monitor with APB registers and interrupt.
 Assumes the tapped stream (data, clock, frame start, server fail) is
 asynchronous to pclk and its clock is well below pclk/4.
*/
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
// Operation
// - Trace byte from J1 accepted after repeats and shown in a register.
// - Per bit, even parity over previous frame compared with received B3.
// - Any B3 bit difference raises one near-end errored block event.
// - G1 bits 1-4: codes 1..8 count one far-end block, others zero.
// - G1 bit 5 gives the remote defect state, one means defect.
// - G1 bits 6 to 8 are ignored.
// - C2 captured every frame for unequipped and AIS detection.
// - Defects use server fail OR AIS in place of server fail.
// - Control bit disables trace mismatch detection.
// - AIS declared after five consecutive all-ones C2 frames.
// - AIS cleared after five consecutive non-all-ones C2 frames.
// - Optional legacy mode judges AIS from the accepted label.
// - Trail fail out is server fail or AIS, unequipped, mismatch.
// - Reports gated by monitoring and by masking defects.
// - Near and far errored blocks and defect seconds counted per second.
module vc3_nonintrusive_monitor #(
    parameter int unsigned SECOND_CYCLES = vc3_mon_pkg::SECOND_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ci_data,
    input wire logic ci_clk,
    input wire logic ci_frame_start,
    input wire logic incoming_server_fail,
    output logic trail_fail_out,
    output logic trail_degrade_out,
    output logic irq
);
    localparam int unsigned NE = vc3_mon_pkg::NUM_EVT;

    typedef struct packed {
        logic ck_prev;
        logic aligned;
        logic first_frame;
        logic [2:0] bit_idx;
        logic [7:0] shreg;
        logic [9:0] byte_pos;
        logic [7:0] parity;
        logic [7:0] prev_parity;
        logic [7:0] c2;
        logic [7:0] acc_label;
        logic [7:0] cand_label;
        logic [2:0] label_cnt;
        logic [7:0] acc_trace;
        logic [7:0] cand_trace;
        logic [2:0] trace_cnt;
        logic [2:0] ais_cnt;
        logic ais;
        logic uneq;
        logic tim;
        logic rdi;
        logic deg;
        logic [7:0] rdi_cand;
        logic [15:0] sec_near;
        logic [15:0] sec_far;
        logic sec_near_def;
        logic sec_far_def;
        logic [3:0] bad_secs;
        logic [31:0] sec_cnt;
        logic [15:0] near_ebc;
        logic [15:0] far_ebc;
        logic [15:0] near_ds;
        logic [15:0] far_ds;
        logic [4:0] ctrl;
        logic [7:0] exp_trace;
        logic [15:0] deg_thr;
        logic [3:0] deg_m;
        logic [NE-1:0] irq_stat;
        logic [NE-1:0] irq_mask;
        logic [NE-1:0] rep_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tsf;
        logic tsd;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [3:0] pins;

    vc3_bit_sync #(.W(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .en(clk_en),
        .din({ci_clk, ci_data, ci_frame_start, incoming_server_fail}),
        .dout(pins)
    );

    logic ck_s;
    logic d_s;
    logic fs_s;
    logic ssf_s;
    assign ck_s = pins[3];
    assign d_s = pins[2];
    assign fs_s = pins[1];
    assign ssf_s = pins[0];

    always_comb begin
        logic rise;
        logic [7:0] byte_v;
        logic byte_done;
        logic ssf_eff;
        logic ais_raw;
        logic near_ev;
        logic far_ev;
        logic mon;
        logic [NE-1:0] rep;
        logic acc;
        rise = 1'b0;
        byte_v = 8'h00;
        byte_done = 1'b0;
        ssf_eff = 1'b0;
        ais_raw = 1'b0;
        near_ev = 1'b0;
        far_ev = 1'b0;
        mon = 1'b0;
        rep = '0;
        acc = 1'b0;
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        rise = ck_s & ~s_q.ck_prev;
        s_d.ck_prev = ck_s;
        if (rise) begin
            byte_v = {s_q.shreg[6:0], d_s};
            s_d.shreg = byte_v;
            if (fs_s) begin
                if (s_q.aligned) begin
                    s_d.prev_parity = s_q.parity;
                    s_d.first_frame = 1'b0;
                end else begin
                    s_d.first_frame = 1'b1;
                end
                s_d.aligned = 1'b1;
                s_d.bit_idx = 3'h1;
                s_d.byte_pos = 10'h000;
                s_d.shreg = {7'h00, d_s};
                s_d.parity = 8'h00;
            end else if (s_q.aligned) begin
                s_d.bit_idx = s_q.bit_idx + 3'h1;
                if (s_q.bit_idx == 3'h7) begin
                    byte_done = 1'b1;
                end
            end
        end
        if (byte_done) begin
            s_d.parity = s_q.parity ^ byte_v;
            if (s_q.byte_pos == vc3_mon_pkg::FRAME_LAST) begin
                s_d.byte_pos = 10'h000;
            end else begin
                s_d.byte_pos = s_q.byte_pos + 10'h001;
            end
            unique case (s_q.byte_pos)
                vc3_mon_pkg::POS_J1: begin
                    if (byte_v == s_q.cand_trace) begin
                        if (s_q.trace_cnt != vc3_mon_pkg::ACCEPT_FRAMES) begin
                            s_d.trace_cnt = s_q.trace_cnt + 3'h1;
                        end else begin
                            s_d.acc_trace = byte_v;
                        end
                    end else begin
                        s_d.cand_trace = byte_v;
                        s_d.trace_cnt = 3'h1;
                    end
                end
                vc3_mon_pkg::POS_B3: begin
                    near_ev = ~s_q.first_frame && (byte_v != s_q.prev_parity);
                end
                vc3_mon_pkg::POS_C2: begin
                    s_d.c2 = byte_v;
                    if (byte_v == s_q.cand_label) begin
                        if (s_q.label_cnt != vc3_mon_pkg::ACCEPT_FRAMES) begin
                            s_d.label_cnt = s_q.label_cnt + 3'h1;
                        end else begin
                            s_d.acc_label = byte_v;
                        end
                    end else begin
                        s_d.cand_label = byte_v;
                        s_d.label_cnt = 3'h1;
                    end
                    ais_raw = (byte_v == vc3_mon_pkg::C2_ALL_ONES);
                    if (s_q.ctrl[vc3_mon_pkg::CTRL_AIS_LEGACY]) begin
                        s_d.ais = (s_d.acc_label == vc3_mon_pkg::C2_ALL_ONES);
                    end else if (ais_raw != s_q.ais) begin
                        if (s_q.ais_cnt == vc3_mon_pkg::AIS_FRAMES - 3'h1) begin
                            s_d.ais = ais_raw;
                            s_d.ais_cnt = 3'h0;
                        end else begin
                            s_d.ais_cnt = s_q.ais_cnt + 3'h1;
                        end
                    end else begin
                        s_d.ais_cnt = 3'h0;
                    end
                    s_d.uneq = (s_d.acc_label == vc3_mon_pkg::C2_UNEQUIPPED);
                end
                vc3_mon_pkg::POS_G1: begin
                    // Bits 6..8 never looked at
                    far_ev = (byte_v[7:4] != 4'h0) && (byte_v[7:4] <= vc3_mon_pkg::REI_MAX);
                    s_d.rdi_cand = {s_q.rdi_cand[6:0], byte_v[3]};
                    if (s_d.rdi_cand[4:0] == 5'h1F) begin
                        s_d.rdi = 1'b1;
                    end else if (s_d.rdi_cand[4:0] == 5'h00) begin
                        s_d.rdi = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        ssf_eff = ssf_s | s_q.ais;
        if (ssf_eff) begin
            s_d.uneq = 1'b0;
            s_d.rdi = 1'b0;
        end
        s_d.tim = ~ssf_eff & ~s_q.ctrl[vc3_mon_pkg::CTRL_TIM_DIS] &
                  (s_q.acc_trace != s_q.exp_trace);
        if (byte_done && s_q.byte_pos == vc3_mon_pkg::POS_B3 && near_ev) begin
            s_d.sec_near = s_q.sec_near + 16'h0001;
        end
        if (byte_done && s_q.byte_pos == vc3_mon_pkg::POS_G1 && far_ev) begin
            s_d.sec_far = s_q.sec_far + 16'h0001;
        end
        s_d.tsf = ssf_s | s_q.ais | s_q.uneq | s_q.tim;
        s_d.tsd = s_q.deg;
        s_d.sec_near_def = s_q.sec_near_def | s_q.tsf;
        s_d.sec_far_def = s_q.sec_far_def | s_q.rdi;
        if (s_q.sec_cnt == SECOND_CYCLES - 1) begin
            s_d.sec_cnt = '0;
            s_d.near_ebc = s_q.near_ebc + s_q.sec_near;
            s_d.far_ebc = s_q.far_ebc + s_q.sec_far;
            s_d.near_ds = s_q.near_ds + {15'h0000, s_q.sec_near_def};
            s_d.far_ds = s_q.far_ds + {15'h0000, s_q.sec_far_def};
            s_d.sec_near = {15'h0000, near_ev};
            s_d.sec_far = {15'h0000, far_ev};
            s_d.sec_near_def = 1'b0;
            s_d.sec_far_def = 1'b0;
            // Degraded: bad seconds in a row declare, one good second clears
            if (ssf_eff) begin
                s_d.bad_secs = 4'h0;
            end else if (s_q.sec_near >= s_q.deg_thr) begin
                if (s_q.bad_secs != s_q.deg_m) begin
                    s_d.bad_secs = s_q.bad_secs + 4'h1;
                end
                s_d.deg = (s_q.bad_secs + 4'h1 >= s_q.deg_m);
            end else begin
                s_d.bad_secs = 4'h0;
                s_d.deg = 1'b0;
            end
        end else begin
            s_d.sec_cnt = s_q.sec_cnt + 32'h0000_0001;
        end
        mon = s_q.ctrl[vc3_mon_pkg::CTRL_MON];
        rep[vc3_mon_pkg::EV_AIS] = s_q.ais & mon;
        rep[vc3_mon_pkg::EV_UNEQ] = s_q.uneq & mon;
        rep[vc3_mon_pkg::EV_TIM] = s_q.tim & ~s_q.uneq & mon;
        rep[vc3_mon_pkg::EV_DEG] = s_q.deg & ~s_q.tim & mon;
        rep[vc3_mon_pkg::EV_RDI] = s_q.rdi & ~s_q.uneq & ~s_q.tim & mon &
                                   s_q.ctrl[vc3_mon_pkg::CTRL_RDI_REP];
        rep[vc3_mon_pkg::EV_SSF] = ssf_eff & mon & s_q.ctrl[vc3_mon_pkg::CTRL_SSF_REP];
        s_d.rep_prev = rep;
        acc = psel & penable;
        s_d.pready = acc & ~s_q.pready;
        if (acc && !s_q.pready) begin
            s_d.prdata = 32'h0000_0000;
            unique case (paddr)
                vc3_mon_pkg::REG_CTRL: begin
                    if (pwrite) begin
                        s_d.ctrl = pwdata[4:0];
                    end
                    s_d.prdata = {27'h0, s_q.ctrl};
                end
                vc3_mon_pkg::REG_STATUS: begin
                    s_d.prdata = {26'h0, rep};
                end
                vc3_mon_pkg::REG_IRQ: begin
                    s_d.prdata = {26'h0, s_q.irq_stat};
                    if (!pwrite) begin
                        s_d.irq_stat = '0;
                    end
                end
                vc3_mon_pkg::REG_MASK: begin
                    if (pwrite) begin
                        s_d.irq_mask = pwdata[NE-1:0];
                    end
                    s_d.prdata = {26'h0, s_q.irq_mask};
                end
                vc3_mon_pkg::REG_EXP_TRACE: begin
                    if (pwrite) begin
                        s_d.exp_trace = pwdata[7:0];
                    end
                    s_d.prdata = {24'h0, s_q.exp_trace};
                end
                vc3_mon_pkg::REG_ACC_TRACE: begin
                    s_d.prdata = {24'h0, s_q.acc_trace};
                end
                vc3_mon_pkg::REG_NEAR_EBC: begin
                    s_d.prdata = {s_q.near_ds, s_q.near_ebc};
                end
                vc3_mon_pkg::REG_FAR_EBC: begin
                    s_d.prdata = {s_q.far_ds, s_q.far_ebc};
                end
                vc3_mon_pkg::REG_DEG: begin
                    if (pwrite) begin
                        s_d.deg_thr = pwdata[15:0];
                        s_d.deg_m = pwdata[19:16];
                    end
                    s_d.prdata = {12'h0, s_q.deg_m, s_q.deg_thr};
                end
                vc3_mon_pkg::REG_SECONDS: begin
                    s_d.prdata = s_q.sec_cnt;
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // New reports set sticky bits; set wins over the read clear
        s_d.irq_stat = s_d.irq_stat | (rep & ~s_q.rep_prev);
        s_d.irq = |(s_d.irq_stat & s_q.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= vc3_mon_pkg::CTRL_RESET;
            s_q.deg_thr <= vc3_mon_pkg::DEG_THR_RESET;
            s_q.deg_m <= vc3_mon_pkg::DEG_M_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign trail_fail_out = s_q.tsf;
    assign trail_degrade_out = s_q.tsd;
    assign irq = s_q.irq;
endmodule : vc3_nonintrusive_monitor

// [hw/vc3_mon_pkg.sv]
/*
 Constants for the VC-3 path non-intrusive monitor: overhead positions,
 register map, codes and timing counts.
 Assumes a 50 MHz pclk and a bit-serial VC-3 stream with a frame-start pulse.
*/
package vc3_mon_pkg;
    // Frame geometry, bytes of a VC-3 (9 rows x 85 columns)
    localparam int unsigned FRAME_BYTES = 765;
    localparam logic [9:0] FRAME_LAST = 10'h2FC;
    localparam logic [9:0] COL_STEP = 10'h055;
    localparam logic [9:0] POS_J1 = 10'h000;
    localparam logic [9:0] POS_B3 = 10'h055;
    localparam logic [9:0] POS_C2 = 10'h0AA;
    localparam logic [9:0] POS_G1 = 10'h0FF;
    localparam logic [7:0] C2_ALL_ONES = 8'hFF;
    localparam logic [7:0] C2_UNEQUIPPED = 8'h00;
    localparam logic [2:0] AIS_FRAMES = 3'h5;
    localparam logic [2:0] ACCEPT_FRAMES = 3'h5;
    localparam logic [3:0] REI_MAX = 4'h8;
    localparam logic [3:0] TRACE_LEN = 4'hF;
    // Timing: one second as cycles of pclk
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned SECOND_CYCLES = CLK_HZ * SECOND_S;
    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0C;
    localparam logic [7:0] REG_EXP_TRACE = 8'h10;
    localparam logic [7:0] REG_ACC_TRACE = 8'h14;
    localparam logic [7:0] REG_NEAR_EBC = 8'h18;
    localparam logic [7:0] REG_FAR_EBC = 8'h1C;
    localparam logic [7:0] REG_DEG = 8'h20;
    localparam logic [7:0] REG_SECONDS = 8'h24;
    // Control bits
    localparam int unsigned CTRL_MON = 0;
    localparam int unsigned CTRL_TIM_DIS = 1;
    localparam int unsigned CTRL_RDI_REP = 2;
    localparam int unsigned CTRL_SSF_REP = 3;
    localparam int unsigned CTRL_AIS_LEGACY = 4;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam logic [15:0] DEG_THR_RESET = 16'h0020;
    localparam logic [3:0] DEG_M_RESET = 4'h2;
    // Status / event bit positions
    localparam int unsigned NUM_EVT = 6;
    localparam int unsigned EV_AIS = 0;
    localparam int unsigned EV_UNEQ = 1;
    localparam int unsigned EV_TIM = 2;
    localparam int unsigned EV_DEG = 3;
    localparam int unsigned EV_RDI = 4;
    localparam int unsigned EV_SSF = 5;
endpackage : vc3_mon_pkg

// [hw/vc3_bit_sync.sv]
/*
 Two-flop synchroniser for a bundle of pin inputs.
 Assumes inputs asynchronous to pclk; output is a level two edges later.
*/
`timescale 1ns/1ps
module vc3_bit_sync #(
    parameter int unsigned W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout <= '0;
        end else if (en) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : vc3_bit_sync

// [verif/vc3_mon_asserts.sv]
/*
 Port-level assertions for the VC-3 non-intrusive monitor.
 Assumes the single pclk domain with async active-low presetn.
*/
`timescale 1ns/1ps
module vc3_mon_asserts #(
    parameter int unsigned SECOND_CYCLES = 2000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ci_data,
    input wire logic ci_clk,
    input wire logic ci_frame_start,
    input wire logic incoming_server_fail,
    input wire logic trail_fail_out,
    input wire logic trail_degrade_out,
    input wire logic irq
);
    logic irq_clr;
    // Only an interrupt status read or a mask write may drop the interrupt
    assign irq_clr = psel && penable && ((paddr == vc3_mon_pkg::REG_IRQ && !pwrite)
        || (paddr == vc3_mon_pkg::REG_MASK && pwrite));
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer; psel && penable && !pready && clk_en |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_pulse; pready && clk_en |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err_pair; pslverr |-> pready; endproperty
    a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
    property p_unmapped; pready && paddr > vc3_mon_pkg::REG_SECONDS |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_mapped;
        pready && paddr <= vc3_mon_pkg::REG_SECONDS && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_rd_stands; !pready |-> $stable(prdata); endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("prdata moved between answers");
    property p_irq_fall; $fell(irq) |-> $past(irq_clr, 1) || $past(irq_clr, 2) || $past(irq_clr, 3); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without clear");
    property p_ssf; (incoming_server_fail && clk_en) [*6] |-> trail_fail_out; endproperty
    a_ssf: assert property (p_ssf) else $error("server fail not passed on");
    property p_frozen;
        !clk_en |=> $stable(trail_fail_out) && $stable(irq) && $stable(pready);
    endproperty
    a_frozen: assert property (p_frozen) else $error("outputs moved while frozen");
endmodule : vc3_mon_asserts

bind vc3_nonintrusive_monitor vc3_mon_asserts #(.SECOND_CYCLES(SECOND_CYCLES)) u_asserts (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ci_data(ci_data), .ci_clk(ci_clk), .ci_frame_start(ci_frame_start),
    .incoming_server_fail(incoming_server_fail), .trail_fail_out(trail_fail_out),
    .trail_degrade_out(trail_degrade_out), .irq(irq)
);

// [verif/vc3_stream_source.sv]
/*
 Behavioural upstream source of a bit-serial VC-3 stream, one frame per run pulse.
 Assumes the bench sets the overhead bytes before raising run.
*/
`timescale 1ns/1ps
module vc3_stream_source (
    input wire logic run,
    input wire logic [7:0] j1_byte,
    input wire logic [7:0] c2_byte,
    input wire logic [7:0] g1_byte,
    input wire logic b3_flip,
    output logic ci_clk,
    output logic ci_data,
    output logic ci_frame_start,
    output int frames_sent
);
    logic [7:0] prev_q;
    logic [7:0] acc;
    logic [7:0] b;
    logic first;
    initial begin
        ci_clk = 1'b0;
        ci_data = 1'b0;
        ci_frame_start = 1'b0;
        frames_sent = 0;
        prev_q = 8'h00;
        first = 1'b1;
    end
    // Clock stands still between frames, so the bench can set the next bytes
    always begin
        wait (run);
        #5;
        acc = 8'h00;
        for (int i = 0; i < vc3_mon_pkg::FRAME_BYTES; i++) begin
            if (i == 0) b = j1_byte;
            else if (i == 85) b = first ? ~prev_q : prev_q ^ {8{b3_flip}};
            else if (i == 170) b = c2_byte;
            else if (i == 255) b = g1_byte;
            else b = i[7:0] ^ 8'h3C;
            acc = acc ^ b;
            for (int k = 7; k >= 0; k--) begin
                ci_data = b[k];
                ci_frame_start = (i == 0) && (k == 7);
                #80 ci_clk = 1'b1;
                #80 ci_clk = 1'b0;
            end
        end
        prev_q = acc;
        first = 1'b0;
        ci_data = ~ci_data;
        frames_sent++;
        wait (!run);
    end
endmodule : vc3_stream_source

// [verif/testbench.sv]
/*
 Self-checking bench for the VC-3 monitor: APB master, stream source, scenarios.
 Assumes a shortened second and a 160 ns link clock; frames are long, so runs are long.
*/
`timescale 1ns/1ps
module testbench;
    localparam int unsigned SEC = 2000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ci_data, ci_clk, ci_frame_start;
    logic incoming_server_fail = 1'b0;
    logic trail_fail_out, trail_degrade_out, irq;
    logic run = 1'b0;
    logic [7:0] c2_byte = 8'h01;
    logic [7:0] g1_byte = 8'h00;
    logic b3_flip = 1'b0;
    int frames_sent;
    int num_errors = 0;
    int samples_checked = 0;

    vc3_nonintrusive_monitor #(.SECOND_CYCLES(SEC)) DUT (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ci_data(ci_data), .ci_clk(ci_clk), .ci_frame_start(ci_frame_start),
        .incoming_server_fail(incoming_server_fail), .trail_fail_out(trail_fail_out),
        .trail_degrade_out(trail_degrade_out), .irq(irq)
    );
    vc3_stream_source partner (
        .run(run), .j1_byte(8'h5A), .c2_byte(c2_byte), .g1_byte(g1_byte), .b3_flip(b3_flip),
        .ci_clk(ci_clk), .ci_data(ci_data), .ci_frame_start(ci_frame_start),
        .frames_sent(frames_sent)
    );

    always #10 pclk = ~pclk;

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask : settle

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        check({31'h0, n < 50}, 32'h1, "apb answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd & m, e, what);
        check({31'h0, err}, 32'h0, "slave error");
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic frame(input logic [7:0] c2, input logic [7:0] g1, input logic flip);
        int start;
        int n;
        start = frames_sent;
        n = 0;
        @(posedge pclk);
        c2_byte <= c2;
        g1_byte <= g1;
        b3_flip <= flip;
        run <= 1'b1;
        while (frames_sent == start && n < 60000) begin
            @(posedge pclk);
            n++;
        end
        run <= 1'b0;
        check(n < 60000, 1, "frame");
        settle(10);
    endtask : frame

    task automatic t_regs();
        logic [31:0] rd;
        logic err;
        rd_chk(vc3_mon_pkg::REG_CTRL, 32'h1F, {27'h0, vc3_mon_pkg::CTRL_RESET}, "ctrl reset");
        rd_chk(vc3_mon_pkg::REG_DEG, 32'hF_FFFF, 32'h2_0020, "deg reset");
        apb(1'b0, 8'h40, 32'h0, rd, err);
        check({31'h0, err}, 32'h1, "unmapped refused");
        check(rd, 32'h0, "unmapped data");
        wr(vc3_mon_pkg::REG_CTRL, 32'h0D);
        wr(vc3_mon_pkg::REG_EXP_TRACE, 32'h5A);
        wr(vc3_mon_pkg::REG_MASK, 32'h21);
        rd_chk(vc3_mon_pkg::REG_CTRL, 32'h1F, 32'h0D, "ctrl write");
    endtask : t_regs

    // Far-end codes with don't-care bits set; one bad parity after the skipped frame
    task automatic t_link_counts();
        logic [3:0] codes [6] = '{4'h1, 4'h8, 4'h9, 4'hF, 4'h0, 4'h2};
        foreach (codes[i]) frame(8'h01, {codes[i], 4'hF}, i == 4);
        rd_chk(vc3_mon_pkg::REG_ACC_TRACE, 32'hFF, 32'h5A, "accepted trace");
        rd_chk(vc3_mon_pkg::REG_STATUS, 32'h16, 32'h10, "remote defect");
        check(trail_fail_out, 32'h0, "no trail fail");
        check(trail_degrade_out, 0, "no degrade");
        settle(SEC + 20);
        rd_chk(vc3_mon_pkg::REG_NEAR_EBC, 32'hFFFF, 32'h1, "near blocks");
        rd_chk(vc3_mon_pkg::REG_FAR_EBC, 32'hFFFF, 32'h3, "far blocks");
    endtask : t_link_counts

    // A frozen block must not pass on the fail flag
    task automatic t_server_fail();
        logic [31:0] rd;
        logic err;
        apb(1'b0, vc3_mon_pkg::REG_IRQ, 32'h0, rd, err);
        @(posedge pclk);
        clk_en <= 1'b0;
        incoming_server_fail <= 1'b1;
        settle(10);
        check(trail_fail_out, 32'h0, "frozen");
        clk_en <= 1'b1;
        settle(10);
        check(trail_fail_out, 32'h1, "server fail");
        check(irq, 32'h1, "irq raised");
        rd_chk(vc3_mon_pkg::REG_STATUS, 32'h20, 32'h20, "server_fail_report_enable");
        rd_chk(vc3_mon_pkg::REG_IRQ, 32'h20, 32'h20, "irq status");
        settle(3);
        check(irq, 32'h0, "irq cleared");
        incoming_server_fail <= 1'b0;
        settle(10);
        check(trail_fail_out, 32'h0, "fail gone");
    endtask : t_server_fail

    task automatic t_ais();
        for (int n = 1; n <= 5; n++) begin
            frame(8'hFF, 8'h07, 1'b0);
            check(trail_fail_out, n == 5, "ais declare");
        end
        check(irq, 32'h1, "ais irq");
        rd_chk(vc3_mon_pkg::REG_IRQ, 32'h01, 32'h01, "ais event");
        for (int n = 1; n <= 5; n++) begin
            frame(8'h01, 8'h07, 1'b0);
            check(trail_fail_out, n < 5, "ais clear");
        end
    endtask : t_ais

    task automatic t_trace();
        wr(vc3_mon_pkg::REG_EXP_TRACE, 32'h33);
        frame(8'h01, 8'h07, 1'b0);
        check(trail_fail_out, 32'h1, "mismatch fails trail");
        rd_chk(vc3_mon_pkg::REG_STATUS, 32'h04, 32'h04, "mismatch reported");
        wr(vc3_mon_pkg::REG_CTRL, 32'h0F);
        frame(8'h01, 8'h07, 1'b0);
        check(trail_fail_out, 32'h0, "mismatch disabled");
        rd_chk(vc3_mon_pkg::REG_STATUS, 32'h04, 32'h00, "mismatch off");
    endtask : t_trace

    // Eighteen frames of about 49k cycles
    initial begin
        repeat (1000000) @(posedge pclk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        t_regs();
        t_link_counts();
        t_server_fail();
        t_ais();
        t_trace();
        wrap_up();
    end
endmodule : testbench
